// File: core/smf_consts.vh
// Summary of operation
// - Status bits 7:1 show target interface address
// - Status bits 15:9 show host interface address
// - Bit 24 flags ROM load finished or failed
// - Bit 25 set on unexpected NACK
// - Lost arbitration retries automatically, no software
// - Sixteen straight losses abort and set bit 26
// - Misplaced START or STOP sets bit 27
// - Bad sum or missing done sets bit 28
// - Load to unmapped register sets bit 29
// - Skip-sum control makes every checksum pass
// - Ignore-loss control continues after lost arbitration
`ifndef SMF_CONSTS_VH
`define SMF_CONSTS_VH

// ==========================================================
// Register map
`define SMF_ADDR_STATUS   12'h424
`define SMF_ADDR_CTRL     12'h428
`define SMF_ADDR_IRQ_STS  12'h440
`define SMF_ADDR_IRQ_MASK 12'h444

// ==========================================================
// Status field positions
`define SMF_TGT_LO        1
`define SMF_TGT_HI        7
`define SMF_HOST_LO       9
`define SMF_HOST_HI       15
`define SMF_LOAD_DONE     24
`define SMF_NACK          25
`define SMF_ARB           26
`define SMF_FRAME         27
`define SMF_SUM           28
`define SMF_UNMAP         29
`define SMF_ERR_LO        25
`define SMF_ERR_HI        29

// ==========================================================
// Control field positions
`define SMF_CTRL_IGN_ARB  16
`define SMF_CTRL_SKIP_SUM 17

// ==========================================================
// Reset values and counts
`define SMF_ERR_RESET     5'h00
`define SMF_ARB_TRIES     5'h10
`define SMF_CAPTURE_WAIT  2'h3

`endif

// File: core/smf_sync.v
`timescale 1ns/100ps
module smf_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  // First stage is read only by the second one
  reg [WIDTH-1:0] meta;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// File: core/smf_cond.v
`timescale 1ns/100ps
module smf_cond
(
  input  wire pclk,
  input  wire presetn,
  input  wire scl,
  input  wire sda,
  output reg  start_seen,
  output reg  stop_seen
);

  // Lines idle high, so reset to high avoids a false edge
  reg scl_q;
  reg sda_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end
    else
    begin
      scl_q      <= scl;
      sda_q      <= sda;
      start_seen <= scl & scl_q & sda_q & ~sda;
      stop_seen  <= scl & scl_q & ~sda_q & sda;
    end
  end

endmodule

// File: core/smf_status.v
`timescale 1ns/100ps
`include "smf_consts.vh"
module smf_status
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output wire        irq,
  input  wire        scl_in,
  input  wire        sda_in,
  input  wire [6:0]  target_addr_strap,
  input  wire [6:0]  host_addr_strap,
  input  wire        rom_load_strap,
  input  wire        host_busy,
  input  wire        txn_start,
  input  wire        nack_seen,
  input  wire        arb_lost,
  input  wire        arb_won,
  input  wire        rom_load_end,
  input  wire        rom_sum_bad,
  input  wire        rom_no_cfg_done,
  input  wire        rom_unmapped,
  output reg         arb_retry,
  output reg         arb_proceed,
  output reg         txn_abort
);

  // ==========================================================
  // Pin synchronisers
  wire [6:0]  tgt_sync;
  wire [6:0]  host_sync;
  wire        load_sync;
  wire        scl_sync;
  wire        sda_sync;
  wire        start_seen;
  wire        stop_seen;

  smf_sync
  #(
    .WIDTH(17)
  )
  u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({scl_in, sda_in, rom_load_strap,
                host_addr_strap, target_addr_strap}),
    .sync_out ({scl_sync, sda_sync, load_sync, host_sync, tgt_sync})
  );

  smf_cond u_cond
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .scl        (scl_sync),
    .sda        (sda_sync),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  // ==========================================================
  // Strap capture after reset release
  reg [1:0] cap_cnt;
  reg       cap_done;
  reg [6:0] target_iface_addr;
  reg [6:0] host_iface_addr;
  reg       load_mode;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_cnt           <= 2'h0;
      cap_done          <= 1'b0;
      target_iface_addr <= 7'h00;
      host_iface_addr   <= 7'h00;
      load_mode         <= 1'b0;
    end
    else if (!cap_done)
    begin
      // Wait out the synchroniser so the captured value is clean
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_cnt == `SMF_CAPTURE_WAIT)
      begin
        cap_done          <= 1'b1;
        target_iface_addr <= tgt_sync;
        host_iface_addr   <= host_sync;
        load_mode         <= load_sync;
      end
    end
  end

  // ==========================================================
  // Bus access decode
  wire       setup_ph = psel & ~penable;
  wire       access   = psel & penable;
  wire       wr_acc   = access & pwrite;
  wire       rd_acc   = access & ~pwrite;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `SMF_ADDR_STATUS) | (a == `SMF_ADDR_CTRL) |
               (a == `SMF_ADDR_IRQ_STS) | (a == `SMF_ADDR_IRQ_MASK);
    end
  endfunction

  assign pready = 1'b1;

  // ==========================================================
  // Control register
  reg ignore_arbitration_loss;
  reg skip_sum_check;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ignore_arbitration_loss <= 1'b0;
      skip_sum_check          <= 1'b0;
    end
    else if (wr_acc && paddr == `SMF_ADDR_CTRL)
    begin
      ignore_arbitration_loss <= pwdata[`SMF_CTRL_IGN_ARB];
      skip_sum_check          <= pwdata[`SMF_CTRL_SKIP_SUM];
    end
  end

  // ==========================================================
  // Arbitration retry counter
  reg [4:0] loss_cnt;
  reg       arb_give_up;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loss_cnt    <= 5'h00;
      arb_retry   <= 1'b0;
      arb_proceed <= 1'b0;
      txn_abort   <= 1'b0;
      arb_give_up <= 1'b0;
    end
    else
    begin
      arb_retry   <= 1'b0;
      arb_proceed <= 1'b0;
      txn_abort   <= 1'b0;
      arb_give_up <= 1'b0;
      if (txn_start || arb_won)
        loss_cnt <= 5'h00;
      else if (arb_lost)
      begin
        if (ignore_arbitration_loss)
          arb_proceed <= 1'b1;
        else if (loss_cnt == `SMF_ARB_TRIES - 5'h01)
        begin
          loss_cnt    <= 5'h00;
          txn_abort   <= 1'b1;
          arb_give_up <= 1'b1;
        end
        else
        begin
          loss_cnt  <= loss_cnt + 5'h01;
          arb_retry <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Boot load tracking
  reg  rom_load_complete;
  wire loading   = load_mode & cap_done & ~rom_load_complete;
  // A sum failure is masked entirely when the check is skipped
  wire sum_fault = loading &
                   ((rom_sum_bad & ~skip_sum_check) |
                    rom_no_cfg_done);
  wire unmap_ev  = loading & rom_unmapped;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rom_load_complete <= 1'b0;
    else if (loading && (rom_load_end || sum_fault || unmap_ev))
      rom_load_complete <= 1'b1;
  end

  // ==========================================================
  // Error events, sticky flags
  wire [4:0] err_ev;
  assign err_ev[0] = nack_seen;
  assign err_ev[1] = arb_give_up;
  assign err_ev[2] = host_busy & (start_seen | stop_seen);
  assign err_ev[3] = sum_fault;
  assign err_ev[4] = unmap_ev;

  reg  [4:0] err_flag;
  reg  [4:0] irq_sts;
  reg  [4:0] irq_mask;
  wire [4:0] w1c_hit;
  wire [4:0] rc_hit;

  assign w1c_hit = (wr_acc && paddr == `SMF_ADDR_STATUS) ?
                   pwdata[`SMF_ERR_HI:`SMF_ERR_LO] : 5'h00;
  assign rc_hit  = (rd_acc && paddr == `SMF_ADDR_IRQ_STS) ?
                   prdata[`SMF_ERR_HI:`SMF_ERR_LO] : 5'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_flag
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          err_flag[gi] <= 1'b0;
          irq_sts[gi]  <= 1'b0;
        end
        else
        begin
          // A new event beats a clear in the same cycle
          if (err_ev[gi])
            err_flag[gi] <= 1'b1;
          else if (w1c_hit[gi])
            err_flag[gi] <= 1'b0;
          if (err_ev[gi])
            irq_sts[gi] <= 1'b1;
          else if (rc_hit[gi])
            irq_sts[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= 5'h00;
    else if (wr_acc && paddr == `SMF_ADDR_IRQ_MASK)
      irq_mask <= pwdata[`SMF_ERR_HI:`SMF_ERR_LO];
  end

  assign irq = |(irq_sts & irq_mask);

  // ==========================================================
  // Read data, fetched in setup so it leaves a flip-flop
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `SMF_ADDR_STATUS:
      begin
        next_rdata[`SMF_TGT_HI:`SMF_TGT_LO]   = target_iface_addr;
        next_rdata[`SMF_HOST_HI:`SMF_HOST_LO] = host_iface_addr;
        next_rdata[`SMF_LOAD_DONE]            = rom_load_complete;
        next_rdata[`SMF_ERR_HI:`SMF_ERR_LO]   = err_flag;
      end
      `SMF_ADDR_CTRL:
      begin
        next_rdata[`SMF_CTRL_IGN_ARB]  = ignore_arbitration_loss;
        next_rdata[`SMF_CTRL_SKIP_SUM] = skip_sum_check;
      end
      `SMF_ADDR_IRQ_STS:
        next_rdata[`SMF_ERR_HI:`SMF_ERR_LO] = irq_sts;
      `SMF_ADDR_IRQ_MASK:
        next_rdata[`SMF_ERR_HI:`SMF_ERR_LO] = irq_mask;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= ~mapped(paddr);
    end
    else if (!psel)
      pslverr <= 1'b0;
  end

endmodule

// File: verification/smf_props.sv
`timescale 1ns/100ps
module smf_props
(
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic [6:0]  target_addr_strap,
  input logic [6:0]  host_addr_strap,
  input logic        txn_start,
  input logic        arb_lost,
  input logic        arb_won,
  input logic        arb_retry,
  input logic        arb_proceed,
  input logic        txn_abort
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cnt;
  wire        rd_sts = psel && penable && !pwrite && paddr == 12'h424;
  // ==========================================
  // Losses since the last start, win or abort
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt <= 8'h00;
    else if (txn_start || arb_won)
      cnt <= 8'h00;
    else if (txn_abort)
      cnt <= arb_lost ? 8'h01 : 8'h00;
    else if (arb_lost)
      cnt <= cnt + 8'h01;
  sequence s_reply;
    arb_retry || arb_proceed || txn_abort;
  endsequence
  // ==========================================
  // Properties
  chk_arb_react: assert property (arb_lost |=> s_reply)
    else $error("no reply to lost arbitration");
  chk_retry_cause: assert property (arb_retry |-> $past(arb_lost))
    else $error("retry without loss");
  chk_abort_count: assert property (txn_abort |-> cnt == 8'h10)
    else $error("abort not on sixteenth loss");
  chk_retry_early: assert property (arb_retry |-> cnt < 8'h10)
    else $error("retry after sixteen losses");
  chk_one_reply: assert property ($onehot0({arb_retry, arb_proceed,
    txn_abort}))
    else $error("several loss replies at once");
  chk_rsvd_zero: assert property (rd_sts |-> prdata[31:30] == 2'h0 &&
    prdata[23:16] == 8'h00 && !prdata[8] && !prdata[0])
    else $error("reserved status bit set");
  chk_tgt_addr: assert property (rd_sts && prdata[7:1] != 7'h00 |->
    prdata[7:1] == target_addr_strap)
    else $error("target address wrong");
  chk_host_addr: assert property (rd_sts && prdata[15:9] != 7'h00 |->
    prdata[15:9] == host_addr_strap)
    else $error("host address wrong");
endmodule

bind smf_status smf_props chk_u
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .target_addr_strap(target_addr_strap),
  .host_addr_strap(host_addr_strap), .txn_start(txn_start),
  .arb_lost(arb_lost), .arb_won(arb_won), .arb_retry(arb_retry),
  .arb_proceed(arb_proceed), .txn_abort(txn_abort)
);

// File: verification/smf_bus_model.sv
`timescale 1ns/100ps
module smf_bus_model
(
  output logic scl,
  output logic sda
);
  // Pulled-up lines idle high; clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Another master's frame: START, two clock pulses of 160 ns period, then STOP
  task frame();
    #3;
    #80 sda = 1'b0;
    #80 scl = 1'b0;
    #80 scl = 1'b1;
    #80 scl = 1'b0;
    #80 scl = 1'b1;
    #80 sda = 1'b1;
  endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [11:0] sts = 12'h424, ctl = 12'h428;
  localparam logic [11:0] ists = 12'h440, imsk = 12'h444;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic scl, sda, host_busy, rom_load_strap, arb_retry, arb_proceed;
  logic txn_abort, se;
  logic [6:0] target_addr_strap, host_addr_strap;
  logic [7:0] ev;
  logic [2:0] r;
  logic [4:0] fl;
  int n_fail, num_checks, i;
  wire txn_start = ev[0], nack_seen = ev[1], arb_lost = ev[2];
  wire arb_won = ev[3], rom_load_end = ev[4], rom_sum_bad = ev[5];
  wire rom_no_cfg_done = ev[6], rom_unmapped = ev[7];
  smf_bus_model bus_u (.scl(scl), .sda(sda));
  smf_status dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl),
    .sda_in(sda), .target_addr_strap(target_addr_strap),
    .host_addr_strap(host_addr_strap), .rom_load_strap(rom_load_strap),
    .host_busy(host_busy), .txn_start(txn_start), .nack_seen(nack_seen),
    .arb_lost(arb_lost), .arb_won(arb_won), .rom_load_end(rom_load_end),
    .rom_sum_bad(rom_sum_bad), .rom_no_cfg_done(rom_no_cfg_done),
    .rom_unmapped(rom_unmapped), .arb_retry(arb_retry),
    .arb_proceed(arb_proceed), .txn_abort(txn_abort)
  );
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================
  // Tasks
  task give_verdict();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Waits on pready even though the slave answers at once
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 40)
    begin
      n_fail++;
      give_verdict();
    end
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev <= 8'h00;
    #1 r = {arb_retry, arb_proceed, txn_abort};
  endtask
  task rs(input logic d);
    apb(0, sts, 0);
    chk("status", rd, {2'h0, fl, d, 8'h00, 7'h55, 1'b0, 7'h2a, 1'b0});
  endtask
  task reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev} = 0;
    {host_busy, fl, n_fail, num_checks} = 0;
    rom_load_strap = 1'b1;
    target_addr_strap = 7'h2a;
    host_addr_strap = 7'h55;
    reset();
    rs(0);
    apb(1, sts, 32'hc0ff_0101);
    rs(0);
    apb(1, imsk, 32'h3e00_0000);
    pulse(1);
    chk("irq", irq, 1);
    fl = 5'h01;
    apb(1, sts, 0);
    rs(0);
    apb(0, ists, 0);
    chk("irq_sts", rd, 32'h0200_0000);
    chk("irq", irq, 0);
    apb(1, imsk, 0);
    pulse(1);
    chk("irq", irq, 0);
    apb(1, sts, 32'h0200_0000);
    fl = 5'h00;
    rs(0);
    pulse(0);
    for (i = 0; i < 27; i++)
    begin
      pulse(i == 10 ? 3 : 2);
      if (i != 10)
        chk("reply", r, i < 26 ? 4 : 1);
    end
    fl = 5'h02;
    bus_u.frame();
    repeat (8) @(posedge pclk);
    rs(0);
    apb(1, ctl, 32'h0001_0000);
    pulse(0);
    pulse(2);
    chk("reply", r, 2);
    @(posedge pclk);
    host_busy <= 1'b1;
    bus_u.frame();
    repeat (8) @(posedge pclk);
    host_busy <= 1'b0;
    fl = 5'h06;
    rs(0);
    apb(1, ctl, 32'h0002_0000);
    pulse(5);
    rs(0);
    apb(1, ctl, 0);
    pulse(6);
    fl = 5'h0e;
    rs(1);
    reset();
    pulse(7);
    fl = 5'h10;
    rs(1);
    reset();
    pulse(4);
    fl = 5'h00;
    rs(1);
    apb(0, 12'h000, 0);
    chk("slverr", se, 1);
    chk("unmapped", rd, 0);
    give_verdict();
  end
endmodule
